// ===== hdl/tpnd_regs.svh
// Register offsets, reset values and read fill values of the timed pulse next-data block
`ifndef TPND_REGS_SVH
`define TPND_REGS_SVH
`define TPND_ADDR_W 16
`define TPND_OFS_TRIG_SEL 16'hffa1
`define TPND_OFS_EN_B 16'hffa2
`define TPND_OFS_EN_A 16'hffa3
`define TPND_OFS_ND_B_UP 16'hffa4
`define TPND_OFS_ND_A_UP 16'hffa5
`define TPND_OFS_ND_B_LO 16'hffa6
`define TPND_OFS_ND_A_LO 16'hffa7
`define TPND_OFS_PORT_A 16'hffd3
`define TPND_OFS_PORT_B 16'hffd6
`define TPND_RST_BYTE 8'h00
`define TPND_RST_TRIG_SEL 8'hff
`define TPND_RSVD_ONES 8'hff
`define TPND_NIB_ONES 4'hf
`define TPND_RDATA_PAD 24'h000000
`endif

// ===== hdl/tpnd_pkg.sv
// Types shared by the timed pulse next-data block
package tpnd_pkg;
  typedef logic [7:0] tpnd_byte_t;
  typedef logic [1:0] tpnd_chan_t;
endpackage

// ===== hdl/tpnd_top.sv
// Next-data staging, enables and trigger-time transfer to the pulse output ports
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "tpnd_regs.svh"

module tpnd_top
  import tpnd_pkg::*;
#(
  parameter int NUM_CHAN = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hw_standby,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_CHAN-1:0] cmp_match,
  output logic [15:0] pulse_out
);

  tpnd_byte_t next_data_a_ff, next_data_b_ff;
  tpnd_byte_t transfer_enable_a_ff, transfer_enable_b_ff;
  tpnd_byte_t port_a_output_data_ff, port_b_output_data_ff;
  tpnd_byte_t trigger_select_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  logic [15:0] pulse_out_ff;

  // Access phase completes in its second cycle: setup, then two access cycles (one wait state)
  wire logic acc = psel & penable & ~pready_ff;
  wire logic wr = acc & pwrite & pstrb[0];
  wire logic [15:0] ofs = paddr[15:0];
  wire logic [31:16] hi_ofs = paddr[31:16];
  wire logic hi_ok = (hi_ofs == 16'hffff);
  wire tpnd_byte_t wb = pwdata[7:0];

  wire logic sel_ts = hi_ok & (ofs == `TPND_OFS_TRIG_SEL);
  wire logic sel_eb = hi_ok & (ofs == `TPND_OFS_EN_B);
  wire logic sel_ea = hi_ok & (ofs == `TPND_OFS_EN_A);
  wire logic sel_bu = hi_ok & (ofs == `TPND_OFS_ND_B_UP);
  wire logic sel_au = hi_ok & (ofs == `TPND_OFS_ND_A_UP);
  wire logic sel_bl = hi_ok & (ofs == `TPND_OFS_ND_B_LO);
  wire logic sel_al = hi_ok & (ofs == `TPND_OFS_ND_A_LO);
  wire logic sel_pa = hi_ok & (ofs == `TPND_OFS_PORT_A);
  wire logic sel_pb = hi_ok & (ofs == `TPND_OFS_PORT_B);
  wire logic mapped = sel_ts | sel_eb | sel_ea | sel_bu | sel_au | sel_bl | sel_al | sel_pa | sel_pb;

  // Per-group trigger source and shared/separate decode
  wire tpnd_chan_t g0_ch = trigger_select_ff[1:0];
  wire tpnd_chan_t g1_ch = trigger_select_ff[3:2];
  wire tpnd_chan_t g2_ch = trigger_select_ff[5:4];
  wire tpnd_chan_t g3_ch = trigger_select_ff[7:6];
  wire logic shared_a = (g0_ch == g1_ch);
  wire logic shared_b = (g2_ch == g3_ch);

  wire logic [3:0] grp_fire;
  assign grp_fire[0] = cmp_match[g0_ch];
  assign grp_fire[1] = cmp_match[g1_ch];
  assign grp_fire[2] = cmp_match[g2_ch];
  assign grp_fire[3] = cmp_match[g3_ch];

  // Next-data write masks per address mapping
  wire tpnd_byte_t nda_wmask = sel_au ? (shared_a ? 8'hff : 8'hf0) :
                               (sel_al & ~shared_a) ? 8'h0f : 8'h00;
  wire tpnd_byte_t ndb_wmask = sel_bu ? (shared_b ? 8'hff : 8'hf0) :
                               (sel_bl & ~shared_b) ? 8'h0f : 8'h00;
  wire tpnd_byte_t nda_wdata = sel_al ? {wb[3:0], wb[3:0]} : wb;
  wire tpnd_byte_t ndb_wdata = sel_bl ? {wb[3:0], wb[3:0]} : wb;
  wire tpnd_byte_t nxt_next_data_a = wr ? ((next_data_a_ff & ~nda_wmask) | (nda_wdata & nda_wmask))
                                        : next_data_a_ff;
  wire tpnd_byte_t nxt_next_data_b = wr ? ((next_data_b_ff & ~ndb_wmask) | (ndb_wdata & ndb_wmask))
                                        : next_data_b_ff;

  // Trigger transfer mask and software write mask for the port data bits
  wire tpnd_byte_t xfer_a = {{4{grp_fire[1]}}, {4{grp_fire[0]}}} & transfer_enable_a_ff;
  wire tpnd_byte_t xfer_b = {{4{grp_fire[3]}}, {4{grp_fire[2]}}} & transfer_enable_b_ff;
  wire tpnd_byte_t swm_a = (wr & sel_pa) ? ~transfer_enable_a_ff : 8'h00;
  wire tpnd_byte_t swm_b = (wr & sel_pb) ? ~transfer_enable_b_ff : 8'h00;
  wire tpnd_byte_t nxt_port_a = (port_a_output_data_ff & ~xfer_a & ~swm_a) | (next_data_a_ff & xfer_a) | (wb & swm_a);
  wire tpnd_byte_t nxt_port_b = (port_b_output_data_ff & ~xfer_b & ~swm_b) | (next_data_b_ff & xfer_b) | (wb & swm_b);

  // Read mux; unused nibbles and reserved locations read as ones
  wire tpnd_byte_t rd_au = shared_a ? next_data_a_ff : {next_data_a_ff[7:4], `TPND_NIB_ONES};
  wire tpnd_byte_t rd_al = shared_a ? `TPND_RSVD_ONES : {`TPND_NIB_ONES, next_data_a_ff[3:0]};
  wire tpnd_byte_t rd_bu = shared_b ? next_data_b_ff : {next_data_b_ff[7:4], `TPND_NIB_ONES};
  wire tpnd_byte_t rd_bl = shared_b ? `TPND_RSVD_ONES : {`TPND_NIB_ONES, next_data_b_ff[3:0]};
  wire tpnd_byte_t rd_byte = sel_ts ? trigger_select_ff :
                             sel_eb ? transfer_enable_b_ff :
                             sel_ea ? transfer_enable_a_ff :
                             sel_bu ? rd_bu :
                             sel_au ? rd_au :
                             sel_bl ? rd_bl :
                             sel_al ? rd_al :
                             sel_pa ? port_a_output_data_ff :
                             sel_pb ? port_b_output_data_ff : `TPND_RST_BYTE;

  // Next-data and port data storage; hardware standby acts as a synchronous clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      next_data_a_ff <= `TPND_RST_BYTE;
      next_data_b_ff <= `TPND_RST_BYTE;
      port_a_output_data_ff <= `TPND_RST_BYTE;
      port_b_output_data_ff <= `TPND_RST_BYTE;
    end else if (hw_standby) begin
      next_data_a_ff <= `TPND_RST_BYTE;
      next_data_b_ff <= `TPND_RST_BYTE;
      port_a_output_data_ff <= `TPND_RST_BYTE;
      port_b_output_data_ff <= `TPND_RST_BYTE;
    end else begin
      next_data_a_ff <= nxt_next_data_a;
      next_data_b_ff <= nxt_next_data_b;
      port_a_output_data_ff <= nxt_port_a;
      port_b_output_data_ff <= nxt_port_b;
    end
  end

  // Enables and trigger select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transfer_enable_a_ff <= `TPND_RST_BYTE;
      transfer_enable_b_ff <= `TPND_RST_BYTE;
      trigger_select_ff <= `TPND_RST_TRIG_SEL;
    end else if (hw_standby) begin
      transfer_enable_a_ff <= `TPND_RST_BYTE;
      transfer_enable_b_ff <= `TPND_RST_BYTE;
      trigger_select_ff <= `TPND_RST_TRIG_SEL;
    end else begin
      if (wr & sel_ea) begin
        transfer_enable_a_ff <= wb;
      end
      if (wr & sel_eb) begin
        transfer_enable_b_ff <= wb;
      end
      if (wr & sel_ts) begin
        trigger_select_ff <= wb;
      end
    end
  end

  // Bus answer and pin register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= {`TPND_RDATA_PAD, `TPND_RST_BYTE};
      pulse_out_ff <= {`TPND_RST_BYTE, `TPND_RST_BYTE};
    end else begin
      pready_ff <= acc;
      pslverr_ff <= acc & ~mapped;
      prdata_ff <= (acc & ~pwrite) ? {`TPND_RDATA_PAD, rd_byte} : {`TPND_RDATA_PAD, `TPND_RST_BYTE};
      // Pins follow the port data registers, so hardware standby clears them in the same edge
      pulse_out_ff <= hw_standby ? {`TPND_RST_BYTE, `TPND_RST_BYTE} : {nxt_port_b, nxt_port_a};
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign pulse_out = pulse_out_ff;

endmodule

// ===== verif/tpnd_props.sv
// Port-level assertions for the timed pulse next-data block
`timescale 1ns/1ps
module tpnd_props #(parameter int NUM_CHAN = 4) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hw_standby,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_CHAN-1:0] cmp_match,
  input wire logic [15:0] pulse_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_standby_trig;
    hw_standby ##1 (|cmp_match);
  endsequence
  a_ready_follow: assert property (s_access |=> pready) else $error("no ready after access");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_ready_cause: assert property (pready |-> psel && penable && $past(penable)) else $error("stray ready");
  a_err_rdata: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error reply");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data outside reply");
  a_out_hold: assert property (!$past(|cmp_match) && !$past(hw_standby) && !(pready && pwrite)
    |-> $stable(pulse_out)) else $error("output moved without cause");
  a_standby_clear: assert property (hw_standby |=> pulse_out == 16'h0) else $error("standby left outputs");
  a_trig_clear: assert property (s_standby_trig |=> pulse_out == 16'h0)
    else $error("trigger moved outputs after standby");
endmodule

// ===== verif/tpnd_timer_model.sv
// Timer-side model turning one-cycle fire requests into compare-match strobes
`timescale 1ns/1ps
module tpnd_timer_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] fire,
  output logic [3:0] cmp_match
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cmp_match <= 4'h0;
    else cmp_match <= fire;
  end
endmodule

// ===== verif/tb.sv
// Self-checking bench for the timed pulse next-data block
`timescale 1ns/1ps
module tb;
  import tpnd_pkg::*;
  logic pclk = 0, presetn = 0, hw_standby = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic [3:0] pstrb = 4'h1, fire = 0, cmp_match;
  logic [15:0] pulse_out;
  int n_errors = 0, cmp_count = 0;
  tpnd_top #(.NUM_CHAN(4)) tpnd_top_inst (.pclk(pclk), .presetn(presetn), .hw_standby(hw_standby), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp_match(cmp_match), .pulse_out(pulse_out));
  tpnd_timer_model tpnd_timer_model_inst (.pclk(pclk), .presetn(presetn), .fire(fire), .cmp_match(cmp_match));
  initial forever #25 pclk = ~pclk;
  task end_of_test;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input tpnd_byte_t d, output tpnd_byte_t r, output logic e);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
    @(posedge pclk);
    penable <= 1;
    // Look at the answer mid-cycle, where it has settled, then let the sampling edge pass
    i = 0;
    @(negedge pclk);
    while (pready !== 1'b1 && i < 20) begin
      @(negedge pclk);
      i++;
    end
    if (i == 20) begin
      n_errors++;
      end_of_test;
    end
    r = prdata[7:0];
    e = pslverr;
    @(posedge pclk);
    {psel, penable} <= 2'b00;
  endtask
  task wr(input logic [15:0] a, input tpnd_byte_t d);
    tpnd_byte_t r;
    logic e;
    apb(1, {16'hffff, a}, d, r, e);
  endtask
  task rdc(input logic [15:0] a, input tpnd_byte_t x);
    tpnd_byte_t r;
    logic e;
    apb(0, {16'hffff, a}, 8'h0, r, e);
    chk(r, x);
  endtask
  // Strobe lands one cycle after the request, outputs settle the cycle after
  task tfire(input logic [3:0] m, input logic [15:0] x);
    @(posedge pclk);
    fire <= m;
    @(posedge pclk);
    fire <= 4'h0;
    repeat (2) @(posedge pclk);
    chk(pulse_out, x);
  endtask
  task t_shared;
    wr(16'hffa5, 8'h5a);
    rdc(16'hffa5, 8'h5a);
    wr(16'hffa7, 8'h00);
    rdc(16'hffa7, 8'hff);
    wr(16'hffa4, 8'hc3);
    wr(16'hffa6, 8'h00);
    rdc(16'hffa6, 8'hff);
    rdc(16'hffa4, 8'hc3);
  endtask
  task t_enable;
    wr(16'hffa3, 8'h0f);
    wr(16'hffa2, 8'hf0);
    rdc(16'hffa3, 8'h0f);
    tfire(4'h4, 16'h0000);
    tfire(4'h8, 16'hc00a);
    wr(16'hffd3, 8'hff);
    rdc(16'hffd3, 8'hfa);
    wr(16'hffd6, 8'h0f);
    rdc(16'hffd6, 8'hcf);
  endtask
  task t_separate;
    wr(16'hffa1, 8'he4);
    rdc(16'hffa5, 8'h5f);
    rdc(16'hffa6, 8'hf3);
    rdc(16'hffa4, 8'hcf);
    wr(16'hffa7, 8'h03);
    rdc(16'hffa7, 8'hf3);
    tfire(4'h1, 16'hcff3);
    tfire(4'h4, 16'hcff3);
  endtask
  task t_unmapped_standby;
    tpnd_byte_t r;
    logic e;
    apb(0, 32'h0000ffa5, 8'h0, r, e);
    chk({e, r}, 9'h100);
    @(posedge pclk);
    {hw_standby, fire} <= 5'h18;
    @(posedge pclk);
    {hw_standby, fire} <= 5'h00;
    repeat (2) @(posedge pclk);
    chk(pulse_out, 16'h0);
    rdc(16'hffa5, 8'h00);
    rdc(16'hffa4, 8'h00);
    rdc(16'hffa2, 8'h00);
    rdc(16'hffa1, 8'hff);
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    rdc(16'hffa3, 8'h00);
    t_shared;
    t_enable;
    t_separate;
    t_unmapped_standby;
    end_of_test;
  end
endmodule
bind tpnd_top tpnd_props #(.NUM_CHAN(NUM_CHAN)) tpnd_props_inst (.pclk(pclk), .presetn(presetn),
  .hw_standby(hw_standby), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cmp_match(cmp_match), .pulse_out(pulse_out));
